/* rtl/phc_pkg.sv */
// constants shared by the printer host port configuration block
package phc_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int XON_PERIOD_MS = 1000;  // repeat x-on every 1 s
  localparam int XON_CYCLES    = CLK_HZ / MS_PER_S * XON_PERIOD_MS;
  localparam int FLASH_HALF_MS = 250;   // lamp on or off time
  localparam int FLASH_CYCLES  = CLK_HZ / MS_PER_S * FLASH_HALF_MS;
  localparam int ERR_FLASHES   = 10;    // flashes before auto resume
  // ==========================================
  // switch positions, index 0 is switch one
  localparam int SW_IO       = 0;
  localparam int SW_BAUD_MSB = 1;
  localparam int SW_BAUD_MID = 2;
  localparam int SW_BAUD_LSB = 3;
  localparam int SW_AUTOCONT = 4;
  localparam int SW_REPEAT   = 5;
  localparam int SW_AUTOSEL  = 6;
  localparam int SW_POL      = 7;
  // ==========================================
  // reset values and codes
  localparam logic [7:0] SW_FACTORY   = 8'h0a;  // serial, 9600
  localparam logic [2:0] BAUD_9600    = 3'h5;
  localparam logic [1:0] SAMPLE_DELAY = 2'h2;   // settle of the synchroniser
  localparam int BAUD_RATES [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 9600};
  localparam int BAUD_DIV_W = 18;
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 8;
endpackage

/* rtl/phc_top.sv */
// host port configuration, flow control and error flash for the printer
// Function
// R1: switch one on selects parallel, else serial
// R2: switches two to four give baud code
// R3: factory default is serial at 9600
// R4: parallel mode ignores all other switches
// R5: host must match the selected baud rate
// R6: auto continue flashes ten times, else waits
// R7: repeat x-on each second while waiting
// R8: auto select switch sets power-up mode
// R9: polarity switch sets dtr ready level
// R10: switches sampled once after reset, then held
`timescale 1ns/1ps

// ==========================================
// data fifo
module phc_fifo #(
  parameter int WIDTH = phc_pkg::BYTE_W,
  parameter int DEPTH = phc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  logic             push;
  logic             pop;

  // handshakes use registered ready and valid
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;

  // occupancy count
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = CW'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = CW'(cnt_reg - 1'b1);
    end
  end

  // storage, written only through the handshake
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and flags, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      in_ready   <= 1'b0;
      out_valid  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
      in_ready   <= (cnt_next != CW'(DEPTH));
      out_valid  <= (cnt_next != '0);
    end
  end

  // head word kept in a flop; bypass when the head slot is written now
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (push && wr_ptr_reg == rd_ptr_next) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[rd_ptr_next];
    end
  end
endmodule

// ==========================================
// configuration and flow control top
module phc_top #(
  parameter int XON_CYC   = phc_pkg::XON_CYCLES,
  parameter int FLASH_CYC = phc_pkg::FLASH_CYCLES,
  parameter int DEPTH     = phc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // switch pins and operator key
  input  wire logic [7:0]                    config_switch_bank,
  input  wire logic                          continue_key,
  // host data in
  input  wire logic                          rx_valid,
  input  wire logic [phc_pkg::BYTE_W-1:0]    rx_data,
  output logic                               rx_ready,
  // data to the formatter
  output logic                               data_valid,
  output logic [phc_pkg::BYTE_W-1:0]         data_out,
  input  wire logic                          data_ready,
  // error event from the engine
  input  wire logic                          print_error,
  // configuration out
  output logic                               cfg_valid,
  output logic                               parallel_sel,
  output logic [2:0]                         baud_code,
  output logic [phc_pkg::BAUD_DIV_W-1:0]     baud_div,
  output logic                               auto_continue_en,
  output logic                               repeat_flow_resume,
  output logic                               auto_select_mode,
  // status and flow control
  output logic                               error_active,
  output logic                               error_lamp,
  output logic                               xon_send,
  output logic                               dtr_out
);
  typedef enum logic {ERR_IDLE, ERR_FLASH} phc_err_t;

  // clocks per bit for a baud code
  function automatic logic [phc_pkg::BAUD_DIV_W-1:0] baud_cycles(input logic [2:0] code);
    baud_cycles = phc_pkg::BAUD_DIV_W'(phc_pkg::CLK_HZ / phc_pkg::BAUD_RATES[code]);
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================
  // pin synchronisers
  logic [7:0] sw_s1_reg;
  logic [7:0] sw_s2_reg;
  logic       key_s1_reg;
  logic       key_s2_reg;
  logic       key_s3_reg;
  logic       key_press;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_s1_reg  <= '0;
      sw_s2_reg  <= '0;
      key_s1_reg <= 1'b0;
      key_s2_reg <= 1'b0;
      key_s3_reg <= 1'b0;
    end else begin
      sw_s1_reg  <= config_switch_bank;
      sw_s2_reg  <= sw_s1_reg;
      key_s1_reg <= continue_key;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
    end
  end
  assign key_press = key_s2_reg && !key_s3_reg;

  // ==========================================
  // one-shot switch capture after reset release
  logic [1:0] samp_cnt_reg;
  logic [7:0] sw_cap_reg;
  logic       dtr_pol_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_reg       <= '0;
      sw_cap_reg         <= phc_pkg::SW_FACTORY;
      cfg_valid          <= 1'b0;
      parallel_sel       <= 1'b0;  // R3
      baud_code          <= phc_pkg::BAUD_9600;
      baud_div           <= baud_cycles(phc_pkg::BAUD_9600);
      auto_continue_en   <= 1'b0;
      repeat_flow_resume <= 1'b0;
      auto_select_mode   <= 1'b0;
      dtr_pol_reg        <= 1'b1;
    end else if (!cfg_valid) begin
      // held until the next power cycle; switches moved later are not seen
      if (samp_cnt_reg != phc_pkg::SAMPLE_DELAY) begin
        samp_cnt_reg <= 2'(samp_cnt_reg + 1'b1);
      end else begin
        cfg_valid    <= 1'b1;  // R10
        sw_cap_reg   <= sw_s2_reg;
        parallel_sel <= sw_s2_reg[phc_pkg::SW_IO];  // R1
        if (!sw_s2_reg[phc_pkg::SW_IO]) begin  // R4
          baud_code <= {sw_s2_reg[phc_pkg::SW_BAUD_MSB], sw_s2_reg[phc_pkg::SW_BAUD_MID],
                        sw_s2_reg[phc_pkg::SW_BAUD_LSB]};  // R2
          baud_div  <= baud_cycles({sw_s2_reg[phc_pkg::SW_BAUD_MSB],
                        sw_s2_reg[phc_pkg::SW_BAUD_MID], sw_s2_reg[phc_pkg::SW_BAUD_LSB]});
          auto_continue_en   <= sw_s2_reg[phc_pkg::SW_AUTOCONT];
          repeat_flow_resume <= sw_s2_reg[phc_pkg::SW_REPEAT];
          auto_select_mode   <= sw_s2_reg[phc_pkg::SW_AUTOSEL];  // R8
          dtr_pol_reg        <= sw_s2_reg[phc_pkg::SW_POL];
        end
      end
    end
  end

  property p_io_sel;
    cfg_valid |-> parallel_sel == sw_cap_reg[phc_pkg::SW_IO];
  endproperty
  a_io_sel: assert property (p_io_sel) else $error("port select differs from switch one"); // R1
  property p_io_cap;
    $rose(cfg_valid) |-> parallel_sel == $past(sw_s2_reg[phc_pkg::SW_IO]);
  endproperty
  a_io_cap: assert property (p_io_cap) else $error("port select not from switch one"); // R1
  property p_baud;
    cfg_valid && !parallel_sel |-> baud_code == {sw_cap_reg[phc_pkg::SW_BAUD_MSB],
      sw_cap_reg[phc_pkg::SW_BAUD_MID], sw_cap_reg[phc_pkg::SW_BAUD_LSB]}
      && baud_div == baud_cycles(baud_code);
  endproperty
  a_baud: assert property (p_baud) else $error("baud code or divider wrong"); // R2
  property p_factory;
    !cfg_valid |-> !parallel_sel && baud_code == phc_pkg::BAUD_9600;
  endproperty
  a_factory: assert property (p_factory) else $error("not at factory default"); // R3
  property p_par_ignore;
    parallel_sel |-> baud_code == phc_pkg::BAUD_9600 && !auto_continue_en
      && !repeat_flow_resume && !auto_select_mode && !xon_send;
  endproperty
  a_par_ignore: assert property (p_par_ignore) else $error("switch used in parallel"); // R4
  property p_autosel;
    cfg_valid |-> auto_select_mode == (sw_cap_reg[phc_pkg::SW_AUTOSEL] && !parallel_sel);
  endproperty
  a_autosel: assert property (p_autosel) else $error("auto select mode wrong"); // R8
  property p_hold;
    cfg_valid |=> cfg_valid && $stable(sw_cap_reg) && $stable(baud_code);
  endproperty
  a_hold: assert property (p_hold) else $error("configuration changed after capture"); // R10

  // ==========================================
  // data fifo between host and formatter
  logic host_ready;

  phc_fifo #(.WIDTH(phc_pkg::BYTE_W), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rx_valid),
    .in_data   (rx_data),
    .in_ready  (rx_ready),
    .out_valid (data_valid),
    .out_data  (data_out),
    .out_ready (data_ready)
  );

  // ==========================================
  // error flash: lamp toggles, full flashes counted on the falling edge
  phc_err_t   err_state_reg;
  logic [31:0] flash_tmr_reg;
  logic [3:0]  flash_cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_state_reg <= ERR_IDLE;
      flash_tmr_reg <= '0;
      flash_cnt_reg <= '0;
      error_lamp    <= 1'b0;
      error_active  <= 1'b0;
    end else begin
      case (err_state_reg)
        ERR_IDLE: begin
          if (print_error) begin
            err_state_reg <= ERR_FLASH;
            error_active  <= 1'b1;
            error_lamp    <= 1'b1;
            flash_tmr_reg <= '0;
            flash_cnt_reg <= '0;
          end
        end
        ERR_FLASH: begin
          // the key always ends the flash, in either mode
          if (key_press) begin
            err_state_reg <= ERR_IDLE;
            error_active  <= 1'b0;
            error_lamp    <= 1'b0;
          end else if (flash_tmr_reg != 32'(FLASH_CYC - 1)) begin
            flash_tmr_reg <= flash_tmr_reg + 32'h1;
          end else begin
            flash_tmr_reg <= '0;
            error_lamp    <= !error_lamp;
            if (error_lamp) begin
              flash_cnt_reg <= 4'(flash_cnt_reg + 1'b1);
              if (auto_continue_en && flash_cnt_reg == 4'(phc_pkg::ERR_FLASHES - 1)) begin
                err_state_reg <= ERR_IDLE;  // R6
                error_active  <= 1'b0;
              end
            end
          end
        end
        default: err_state_reg <= ERR_IDLE;
      endcase
    end
  end

  property p_flash_limit;
    error_active && auto_continue_en |-> flash_cnt_reg < 4'(phc_pkg::ERR_FLASHES);
  endproperty
  a_flash_limit: assert property (p_flash_limit) else $error("more than ten flashes"); // R6
  property p_flash_hold;
    error_active && !auto_continue_en && !key_press |=> error_active;
  endproperty
  a_flash_hold: assert property (p_flash_hold) else $error("resumed without key"); // R6

  // ==========================================
  // x-on: once on entry to waiting, repeated each period when enabled
  logic        wait_reg;
  logic [31:0] xon_tmr_reg;
  logic        waiting;

  assign waiting = cfg_valid && !parallel_sel && !error_active && !data_valid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg    <= 1'b0;
      xon_tmr_reg <= '0;
      xon_send    <= 1'b0;
    end else begin
      wait_reg <= waiting;
      xon_send <= 1'b0;
      if (waiting && !wait_reg) begin
        xon_send    <= 1'b1;  // R7
        xon_tmr_reg <= '0;
      end else if (waiting && repeat_flow_resume) begin
        if (xon_tmr_reg == 32'(XON_CYC - 1)) begin
          xon_send    <= 1'b1;  // R7
          xon_tmr_reg <= '0;
        end else begin
          xon_tmr_reg <= xon_tmr_reg + 32'h1;
        end
      end
    end
  end

  property p_xon_edge;
    waiting && !wait_reg |=> xon_send;
  endproperty
  a_xon_edge: assert property (p_xon_edge) else $error("no x-on on entry to waiting"); // R7
  property p_xon_single;
    xon_send && !repeat_flow_resume |=> !xon_send;
  endproperty
  a_xon_single: assert property (p_xon_single) else $error("x-on repeated"); // R7

  // ==========================================
  // dtr level follows readiness with the captured polarity
  assign host_ready = cfg_valid && !error_active && rx_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_out <= 1'b0;
    end else begin
      dtr_out <= dtr_pol_reg ? host_ready : !host_ready;  // R9
    end
  end

  property p_dtr;
    cfg_valid |=> dtr_out == ($past(dtr_pol_reg) ~^ $past(host_ready));
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr level wrong"); // R9

  c_auto_resume: cover property ($fell(error_active) && auto_continue_en);
  c_xon_repeat:  cover property (xon_send && repeat_flow_resume && wait_reg);
  c_fifo_full:   cover property (rx_valid && !rx_ready);
  c_parallel:    cover property ($rose(cfg_valid) ##1 parallel_sel);
endmodule

/* tb/phc_host_model.sv */
// host computer model: sends bytes to the port and counts flow-resume characters
`timescale 1ns/1ps
module phc_host_model (
  // clock
  input  wire logic       clk,
  // byte link
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  // flow control seen by the host
  input  wire logic       xon_send,
  output int              xon_count,
  output logic            host_err
);
  // ==========================================
  // idle link, no byte offered
  initial begin
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    xon_count = 0;
    host_err  = 1'b0;
  end
  // each pulse stands for one resume character on the wire
  always @(posedge clk) begin
    if (xon_send === 1'b1) xon_count <= xon_count + 1;
  end
  // ==========================================
  // one byte held until taken; host runs at the printer's rate
  task automatic send_byte(input logic [7:0] b, input int gap);
    int n;
    n = 0;
    repeat (gap) @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    do begin
      @(posedge clk);
      n++;
    end while (rx_ready !== 1'b1 && n < 200);
    if (n >= 200) host_err <= 1'b1;
    rx_valid <= 1'b0;
    rx_data  <= ~b; // released line must not look like a stale byte
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the host port configuration block
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // short counts so flashing and repeats fit in a quick run
  localparam int XC = 20;
  localparam int FC = 4;
  localparam int RATE [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 9600}; // unused code: 9600
  logic        clk, rst_n, continue_key, print_error, data_ready;
  logic [7:0]  sw_bank;
  logic        rx_valid, rx_ready, data_valid, cfg_valid, parallel_sel, host_err;
  logic [7:0]  rx_data, data_out;
  logic [2:0]  baud_code;
  logic [17:0] baud_div;
  logic        auto_cont, rep_flow, auto_sel, err_act, err_lamp, xon_send, dtr_out;
  int          xon_count, err_total, check_count, c0;
  phc_top #(.XON_CYC(XC), .FLASH_CYC(FC)) phc_top_inst (
    .clk(clk), .rst_n(rst_n), .config_switch_bank(sw_bank), .continue_key(continue_key),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .data_valid(data_valid), .data_out(data_out), .data_ready(data_ready),
    .print_error(print_error), .cfg_valid(cfg_valid), .parallel_sel(parallel_sel),
    .baud_code(baud_code), .baud_div(baud_div), .auto_continue_en(auto_cont),
    .repeat_flow_resume(rep_flow), .auto_select_mode(auto_sel), .error_active(err_act),
    .error_lamp(err_lamp), .xon_send(xon_send), .dtr_out(dtr_out));
  phc_host_model phc_host_model_inst (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .xon_send(xon_send), .xon_count(xon_count), .host_err(host_err));
  // ==========================================
  // clock and time-zero values
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    sw_bank = 8'h0a;
    continue_key = 1'b0;
    print_error = 1'b0;
    data_ready = 1'b0;
    err_total = 0;
    check_count = 0;
  end
  // ==========================================
  // reporting
  task automatic test_done();
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
      err_total++;
    end
  endtask
  task automatic hang(input string name);
    $display("unexpected %s expected %0h seen %0h", name, 1, 0);
    err_total++;
    test_done();
  endtask
  // ==========================================
  // access tasks: power cycle with a switch pattern, pull a byte, error pulse
  task automatic boot(input logic [7:0] sw);
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    sw_bank <= sw;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cfg_valid !== 1'b1 && n < 10);
    if (n >= 10) hang("cfg_valid");
  endtask
  task automatic pull_byte(input logic [7:0] exp);
    int n;
    n = 0;
    data_ready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (data_valid !== 1'b1 && n < 50);
    if (n >= 50) hang("data_valid");
    check("data_out", exp, data_out);
    data_ready <= 1'b0;
    // one idle edge so a following pull never re-raises ready in this step
    @(posedge clk);
  endtask
  task automatic err_pulse();
    @(posedge clk);
    print_error <= 1'b1;
    @(posedge clk);
    print_error <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  initial begin
    logic [7:0] sw;
    int n, rises;
    logic prev;
    boot(8'h0a);
    check("parallel_sel", 0, parallel_sel);
    check("baud_code", 5, baud_code);
    check("baud_div", 5208, baud_div);
    repeat (3) @(posedge clk);
    check("dtr_out", 0, dtr_out);
    sw_bank <= 8'hff;
    repeat (10) @(posedge clk);
    check("parallel_sel", 0, parallel_sel);
    check("baud_code", 5, baud_code);
    // every baud code, with switches five to seven varied alongside and the polarity switch held on
    for (int c = 0; c < 8; c++) begin
      sw = {~c[3:0], c[0], c[1], c[2], 1'b0};
      boot(sw);
      check("baud_code", c, baud_code);
      check("baud_div", 50_000_000 / RATE[c], baud_div);
      check("auto_continue_en", sw[4], auto_cont);
      check("repeat_flow_resume", sw[5], rep_flow);
      check("auto_select_mode", sw[6], auto_sel);
      repeat (3) @(posedge clk);
      check("dtr_out", 1, dtr_out);
    end
    // parallel: other switches have no effect, no flow characters
    boot(8'hff);
    check("parallel_sel", 1, parallel_sel);
    check("auto_continue_en", 0, auto_cont);
    check("repeat_flow_resume", 0, rep_flow);
    check("auto_select_mode", 0, auto_sel);
    check("baud_code", 5, baud_code);
    c0 = xon_count;
    repeat (90) @(posedge clk);
    check("xon_count", 0, xon_count - c0);
    // repeated resume: one pulse per XC cycles while waiting
    boot(8'h2a);
    c0 = xon_count;
    repeat (90) @(posedge clk);
    check("xon_count", 5, xon_count - c0);
    // single resume, then one more after data is used up
    boot(8'h0a);
    c0 = xon_count;
    repeat (90) @(posedge clk);
    check("xon_count", 1, xon_count - c0);
    phc_host_model_inst.send_byte(8'h5a, 1);
    pull_byte(8'h5a);
    repeat (40) @(posedge clk);
    check("xon_count", 2, xon_count - c0);
    // fill the buffer until it refuses, then drain in order
    for (int i = 0; i < 8; i++) phc_host_model_inst.send_byte(8'h11 * i + 8'h01, 1);
    repeat (2) @(posedge clk);
    check("rx_ready", 0, rx_ready);
    for (int i = 0; i < 8; i++) pull_byte(8'h11 * i + 8'h01);
    // manual continue: flashing outlasts ten flashes until the key
    boot(8'h8a);
    err_pulse();
    repeat (3) @(posedge clk);
    check("error_active", 1, err_act);
    check("dtr_out", 0, dtr_out);
    repeat (100) @(posedge clk);
    check("error_active", 1, err_act);
    continue_key <= 1'b1;
    repeat (4) @(posedge clk);
    continue_key <= 1'b0;
    n = 0;
    while (err_act !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("error_active", 0, err_act);
    repeat (3) @(posedge clk);
    check("dtr_out", 1, dtr_out);
    // auto continue: exactly ten flashes, then resume
    boot(8'h1a);
    err_pulse();
    n = 0;
    rises = 0;
    prev = 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (err_lamp === 1'b1 && prev === 1'b0) rises++;
      prev = err_lamp;
    end while ((n < 3 || err_act === 1'b1) && n < 300);
    check("flash_count", 10, rises);
    check("error_active", 0, err_act);
    check("host_err", 0, host_err);
    test_done();
  end
  // overall guard against a hang
  initial begin
    repeat (100000) @(posedge clk);
    hang("run_length");
  end
endmodule
